// *** hw/bzcd_detector.sv ***
// Overview of operation
// - Phase inputs: comparator or sensor logic
// - Two-bit select steers one phase input
// - Two-bit field picks comparator reference
// - Zero-cross sampling paced by window/PWM
// - Demag comparator sampled at fixed rate
// - Order: commutation, demag, then zero-cross
// - Edge/level bits classify comparator transitions
// - 20us blanking of demag after commutation
// - 20us blanking of zero-cross after demag
// - Hardware demag captures timer into register
// - Timer match gives simulated demag
// - Both enabled: first source wins
// - Demag sets flag, masked interrupt request
// - After C and D, regroup PWM, sample
// - Sense group select qualifies sensorless zero-cross
// - Zero-cross sets flag, masked interrupt request
// - Zero-cross pulses delay manager trigger
// - Mode bit selects sensor or sensorless
// - Sensor mode: fixed rate, no demag
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module bzcd_detector
  import bzcd_pkg::*;
#(
  parameter int unsigned FILTER_LEN = FILTER_CYCLES
) (
  input  wire logic       core_clk_i,
  input  wire logic       rstn_i,
  input  wire logic [3:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  input  wire logic [2:0] cmp_out_i,
  input  wire logic       commutation_i,
  input  wire logic [7:0] motor_timer_i,
  input  wire logic       pwm_sample_i,
  input  wire logic       pwm_odd_active_i,
  input  wire logic       pwm_even_active_i,
  output logic      [1:0] input_select_o,
  output logic      [1:0] reference_level_select_o,
  output logic      [2:0] output_group_config_o,
  output logic            pwm_regroup_o,
  output logic            demag_irq_o,
  output logic            zero_cross_irq_o,
  output logic            delay_trigger_o
);

  bzcd_bus_s  bus;
  bzcd_step_e step;
  logic [7:0] ctrl;
  logic [7:0] sel;
  logic [3:0] sampling_rate_field;
  logic [7:0] demag_time_reg;
  logic [1:0] status;
  logic [1:0] mask;
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic       sel_level;
  logic       sample_prev;
  logic [15:0] fix_cnt;
  logic       fix_tick;
  logic [11:0] win_cnt;
  logic       win_tick;
  logic [$clog2(FILTER_LEN+1)-1:0] blank_cnt;
  logic       expect_d;
  logic       expect_z;
  logic       hw_d;
  logic       sw_d;
  logic       d_evt;
  logic       z_tick;
  logic       z_qual;
  logic       z_evt;
  logic       blank_done;

  assign bus = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

  function automatic logic is_wr(input bzcd_bus_s b, input logic [3:0] a);
    is_wr = b.wr && (b.addr == a);
  endfunction : is_wr

  // Last count of the fixed divider; shared by the tick and the wrap
  function automatic logic fix_last(input logic [15:0] cnt);
    fix_last = (cnt == 16'(FIXED_SAMPLE_DIV - 1));
  endfunction : fix_last

  // Window period follows the sampling field; a lowered field wraps at once
  function automatic logic win_last(input logic [11:0] cnt, input logic [3:0] rate);
    win_last = (cnt >= 12'(WINDOW_BASE_DIV * (32'(rate) + 1)) - 12'h001);
  endfunction : win_last

  // Control register
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl <= CTRL_RESET;
    end else if (is_wr(bus, ADDR_CTRL)) begin
      ctrl <= bus.wdata;
    end
  end

  // Phase, reference and output group selection
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sel <= SEL_RESET;
    end else if (is_wr(bus, ADDR_SEL)) begin
      sel <= bus.wdata;
    end
  end

  // Interrupt masks share their register with the sampling rate
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mask                <= 2'h0;
      sampling_rate_field <= 4'h0;
    end else if (is_wr(bus, ADDR_MASK)) begin
      mask                <= bus.wdata[1:0];
      sampling_rate_field <= bus.wdata[7:4];
    end
  end

  // Field outputs: select[1:0], reference[3:2], group config[6:4]
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      input_select_o <= 2'h0;
    end else begin
      input_select_o <= sel[1:0];
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reference_level_select_o <= 2'h0;
    end else begin
      reference_level_select_o <= sel[3:2];
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      output_group_config_o <= 3'h0;
    end else begin
      output_group_config_o <= sel[6:4];
    end
  end

  // Comparator (sensorless) or sensor logic arrives as a digital level
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
    end else begin
      sync1 <= cmp_out_i;
      sync2 <= sync1;
    end
  end

  always_comb begin
    unique case (sel[1:0])
      2'h0:    sel_level = sync2[0];
      2'h1:    sel_level = sync2[1];
      2'h2:    sel_level = sync2[2];
      default: sel_level = 1'b0;
    endcase
  end

  // Fixed 800 kHz tick
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fix_cnt  <= 16'h0000;
      fix_tick <= 1'b0;
    end else begin
      fix_tick <= fix_last(fix_cnt);
      fix_cnt  <= fix_last(fix_cnt) ? 16'h0000 : fix_cnt + 16'h0001;
    end
  end

  // Window generator for current mode; period grows with sampling field
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      win_cnt  <= 12'h000;
      win_tick <= 1'b0;
    end else begin
      win_tick <= win_last(win_cnt, sampling_rate_field);
      if (win_last(win_cnt, sampling_rate_field)) begin
        win_cnt <= 12'h000;
      end else begin
        win_cnt <= win_cnt + 12'h001;
      end
    end
  end

  always_comb begin
    if (ctrl[CTRL_SENSOR]) begin
      z_tick = fix_tick;
    end else if (ctrl[CTRL_CURR]) begin
      z_tick = win_tick;
    end else begin
      z_tick = pwm_sample_i;
    end
  end

  // Expected levels: D edge goes toward the rail opposite of the Z result
  assign expect_z = ctrl[CTRL_CPB] ^ ctrl[CTRL_ZVD];
  assign expect_d = ~expect_z;

  assign hw_d = ctrl[CTRL_HDM] && fix_tick && (sel_level == expect_d)
                && (sample_prev != sel_level);
  assign sw_d = ctrl[CTRL_SDM] && (motor_timer_i == demag_time_reg);
  assign blank_done = (blank_cnt == '0);
  assign d_evt = !ctrl[CTRL_SENSOR] && (step == BZCD_WAIT_D) && blank_done
                 && (hw_d || sw_d);

  // Group qualification; sensor mode reads in any window
  assign z_qual = ctrl[CTRL_SENSOR] || (ctrl[CTRL_REO] ? pwm_odd_active_i
                                                      : pwm_even_active_i);
  assign z_evt = (step == BZCD_WAIT_Z) && blank_done && z_tick && z_qual
                 && (sel_level == expect_z) && (sample_prev != sel_level);

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sample_prev <= 1'b0;
    end else if ((z_tick && step == BZCD_WAIT_Z) || (fix_tick && step != BZCD_WAIT_Z)) begin
      sample_prev <= sel_level;
    end
  end

  // Step sequencer with blanking counter
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      step      <= BZCD_WAIT_C;
      blank_cnt <= '0;
    end else begin
      if (blank_cnt != '0) begin
        blank_cnt <= blank_cnt - 1'b1;
      end
      if (commutation_i) begin
        step      <= ctrl[CTRL_SENSOR] ? BZCD_WAIT_Z : BZCD_WAIT_D;
        blank_cnt <= ($bits(blank_cnt))'(FILTER_LEN);
      end else begin
        unique case (step)
          BZCD_WAIT_C: step <= BZCD_WAIT_C;
          BZCD_WAIT_D: begin
            if (d_evt) begin
              step      <= BZCD_WAIT_Z;
              blank_cnt <= ($bits(blank_cnt))'(FILTER_LEN);
            end
          end
          BZCD_WAIT_Z: begin
            if (z_evt) begin
              step <= BZCD_WAIT_C;
            end
          end
        endcase
      end
    end
  end

  // Demag time register: capture on hardware edge, software write otherwise
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      demag_time_reg <= DEMAG_RESET;
    end else if (d_evt && hw_d) begin
      demag_time_reg <= motor_timer_i;
    end else if (is_wr(bus, ADDR_DEMAG)) begin
      demag_time_reg <= bus.wdata;
    end
  end

  // Sticky flags; write one to clear, new event wins over clear
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      status <= 2'h0;
    end else begin
      status[ST_DEMAG] <= d_evt || (status[ST_DEMAG]
                          && !(is_wr(bus, ADDR_STATUS) && bus.wdata[ST_DEMAG]));
      status[ST_ZERO]  <= z_evt || (status[ST_ZERO]
                          && !(is_wr(bus, ADDR_STATUS) && bus.wdata[ST_ZERO]));
    end
  end

  // Event term included so the request rises with the flag, not after it
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      demag_irq_o <= 1'b0;
    end else begin
      demag_irq_o <= (status[ST_DEMAG] || d_evt) && mask[ST_DEMAG];
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      zero_cross_irq_o <= 1'b0;
    end else begin
      zero_cross_irq_o <= (status[ST_ZERO] || z_evt) && mask[ST_ZERO];
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      delay_trigger_o <= 1'b0;
    end else begin
      delay_trigger_o <= z_evt;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pwm_regroup_o <= 1'b0;
    end else begin
      pwm_regroup_o <= (step == BZCD_WAIT_Z);
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= 8'h00;
    end else if (bus.rd) begin
      unique case (bus.addr)
        ADDR_CTRL:   reg_rdata_o <= ctrl;
        ADDR_SEL:    reg_rdata_o <= sel;
        ADDR_DEMAG:  reg_rdata_o <= demag_time_reg;
        // Live level kept clear of the flag bits so a read never fakes a flag
        ADDR_STATUS: reg_rdata_o <= {3'h0, sel_level, step, status};
        ADDR_MASK:   reg_rdata_o <= {sampling_rate_field, 2'h0, mask};
        ADDR_TIMER:  reg_rdata_o <= motor_timer_i;
        default:     reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

endmodule : bzcd_detector

// *** hw/bzcd_pkg.sv ***
package bzcd_pkg;
  localparam int unsigned CLK_MHZ           = 250;
  localparam int unsigned FILTER_US         = 20;
  localparam int unsigned FILTER_CYCLES     = FILTER_US * CLK_MHZ;
  localparam int unsigned FIXED_SAMPLE_KHZ  = 800;
  localparam int unsigned FIXED_SAMPLE_DIV  = (CLK_MHZ * 1000) / FIXED_SAMPLE_KHZ;
  localparam int unsigned WINDOW_BASE_DIV   = 64;

  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_SEL    = 4'h1;
  localparam logic [3:0] ADDR_DEMAG  = 4'h2;
  localparam logic [3:0] ADDR_STATUS = 4'h3;
  localparam logic [3:0] ADDR_MASK   = 4'h4;
  localparam logic [3:0] ADDR_TIMER  = 4'h5;

  localparam int unsigned CTRL_SENSOR = 0;
  localparam int unsigned CTRL_HDM    = 1;
  localparam int unsigned CTRL_SDM    = 2;
  localparam int unsigned CTRL_CPB    = 3;
  localparam int unsigned CTRL_ZVD    = 4;
  localparam int unsigned CTRL_REO    = 5;
  localparam int unsigned CTRL_CURR   = 6;

  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [7:0] SEL_RESET    = 8'h00;
  localparam logic [7:0] DEMAG_RESET  = 8'h00;

  localparam int unsigned ST_DEMAG = 0;
  localparam int unsigned ST_ZERO  = 1;
  localparam int unsigned ST_COMP  = 2;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bzcd_bus_s;

  typedef enum logic [1:0] {
    BZCD_WAIT_C,
    BZCD_WAIT_D,
    BZCD_WAIT_Z
  } bzcd_step_e;
endpackage : bzcd_pkg

// *** sim/bzcd_detector_sva.sv ***
`timescale 1ns/1ps
module bzcd_detector_sva
  import bzcd_pkg::*;
#(
  parameter int unsigned FILTER_LEN = FILTER_CYCLES
) (
  input wire logic       core_clk_i,
  input wire logic       rstn_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_wr_i,
  input wire logic       commutation_i,
  input wire logic [1:0] input_select_o,
  input wire logic [1:0] reference_level_select_o,
  input wire logic [2:0] output_group_config_o,
  input wire logic       pwm_regroup_o,
  input wire logic       demag_irq_o,
  input wire logic       zero_cross_irq_o,
  input wire logic       delay_trigger_o
);
  logic [1:0]  msk;
  logic        zdone;
  int unsigned rgc;
  int unsigned cc;
  // Mask shadow rebuilt from the strobes, so no internal probe is needed
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      msk <= 2'h0;
      zdone <= 1'b0;
      rgc <= 0;
      cc <= 0;
    end else begin
      if (reg_wr_i && reg_addr_i == ADDR_MASK) msk <= reg_wdata_i[1:0];
      zdone <= commutation_i ? 1'b0 : (zdone | delay_trigger_o);
      rgc <= pwm_regroup_o ? rgc + 1 : 0;
      cc <= commutation_i ? 0 : cc + 1;
    end
  end
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);
  // Second cycle free of writes, so either output latency passes
  sequence s_sel_wr;
    reg_wr_i && reg_addr_i == ADDR_SEL ##1 !reg_wr_i;
  endsequence
  a_sel_input_copy: assert property (s_sel_wr |=> input_select_o == $past(reg_wdata_i[1:0], 2))
    else $error("input select not taken");
  a_sel_ref_copy: assert property (s_sel_wr |=> reference_level_select_o == $past(reg_wdata_i[3:2], 2))
    else $error("reference select not taken");
  a_sel_group_copy: assert property (s_sel_wr |=> output_group_config_o == $past(reg_wdata_i[6:4], 2))
    else $error("output group not taken");
  a_dirq_masked: assert property (demag_irq_o |-> $past(msk[0]))
    else $error("demag irq while masked");
  a_zirq_masked: assert property (zero_cross_irq_o |-> $past(msk[1]))
    else $error("zero irq while masked");
  a_trig_sets_zirq: assert property (delay_trigger_o && $past(msk[1]) |-> zero_cross_irq_o)
    else $error("trigger without zero irq");
  a_zirq_sticky: assert property (zero_cross_irq_o && !$past(reg_wr_i && (reg_addr_i == ADDR_STATUS
    || reg_addr_i == ADDR_MASK)) |=> zero_cross_irq_o)
    else $error("zero irq dropped");
  a_one_zero_cross: assert property (delay_trigger_o |-> !zdone)
    else $error("second zero cross in step");
  a_trig_after_regroup: assert property (delay_trigger_o |-> $past(pwm_regroup_o))
    else $error("zero cross out of order");
  a_z_blanking: assert property (delay_trigger_o |-> rgc >= FILTER_LEN - 2)
    else $error("zero cross inside blanking");
  a_d_blanking: assert property ($rose(demag_irq_o) && $past(msk[0], 2) |-> cc >= FILTER_LEN)
    else $error("demag inside blanking");
endmodule : bzcd_detector_sva
bind bzcd_detector bzcd_detector_sva #(.FILTER_LEN(FILTER_LEN)) bzcd_detector_sva_i (.*);

// *** sim/bzcd_motor_model.sv ***
`timescale 1ns/1ps
module bzcd_motor_model (
  input  wire logic        clk_i,
  input  wire logic        commutation_i,
  input  wire logic [1:0]  phase_i,
  input  wire logic        pol_i,
  input  wire logic [15:0] d_dly_i,
  input  wire logic [15:0] z_dly_i,
  output logic      [2:0]  phase_o
);
  logic [15:0] age = 16'hffff;
  logic        tgl = 1'b0;
  logic        lvl;
  always @(posedge clk_i) begin
    tgl <= !tgl;
    if (commutation_i) age <= 16'h0000;
    else if (age != 16'hffff) age <= age + 16'h0001;
  end
  // Rail while demagnetising, then back-EMF, then the crossing
  assign lvl = (age < d_dly_i) ? pol_i : (age < d_dly_i + z_dly_i) ? !pol_i : pol_i;
  // Other windings wobble each cycle, so a wrong mux pick shows
  always_comb begin
    phase_o = {3{tgl}};
    if (phase_i != 2'h3) phase_o[phase_i] = lvl;
  end
endmodule : bzcd_motor_model

// *** sim/tb_bzcd_detector.sv ***
`timescale 1ns/1ps
module tb_bzcd_detector import bzcd_pkg::*;;
  logic        core_clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic [3:0]  reg_addr_i = 4'h0;
  logic [7:0]  reg_wdata_i = 8'h00;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic        commutation_i = 1'b0;
  logic [7:0]  motor_timer_i = 8'h00;
  logic        pwm_sample_i = 1'b0;
  logic        pwm_odd_active_i = 1'b0;
  logic        pwm_even_active_i = 1'b1;
  logic [7:0]  reg_rdata_o;
  logic [2:0]  cmp_out_i;
  logic [1:0]  input_select_o, reference_level_select_o;
  logic [2:0]  output_group_config_o;
  logic        pwm_regroup_o, demag_irq_o, zero_cross_irq_o, delay_trigger_o;
  logic [7:0]  tbase = 8'h00;
  logic        trun = 1'b0;
  logic [3:0]  pcnt = 4'h0;
  logic [1:0]  mph = 2'h0;
  logic        mpol = 1'b0;
  logic [15:0] ddly = 16'd400;
  logic [15:0] zdly = 16'd600;
  int          bad_count = 0;
  int          n_checks = 0;
  int          trig_n = 0;
  bzcd_detector #(.FILTER_LEN(20)) bzcd_detector_i (.*);
  bzcd_motor_model bzcd_motor_model_i (.clk_i(core_clk_i), .commutation_i(commutation_i),
    .phase_i(mph), .pol_i(mpol), .d_dly_i(ddly), .z_dly_i(zdly), .phase_o(cmp_out_i));
  initial begin
    forever #2 core_clk_i = !core_clk_i;
  end
  always @(posedge core_clk_i) begin
    motor_timer_i <= commutation_i ? tbase : motor_timer_i + {7'h00, trun};
    pcnt <= pcnt + 4'h1;
    pwm_sample_i <= (pcnt == 4'h0);
  end
  always @(negedge core_clk_i) if (delay_trigger_o === 1'b1) trig_n++;
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string s);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: %s got %h expected %h", $time, s, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task automatic rchk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e,
                      input string s);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge core_clk_i);
    chk(reg_rdata_o & m, e, s);
  endtask : rchk
  task automatic step(input logic [7:0] sel, input logic [7:0] ctl, input logic [7:0] msk);
    wr(ADDR_SEL, sel);
    wr(ADDR_CTRL, ctl);
    wr(ADDR_MASK, msk);
    @(posedge core_clk_i);
    commutation_i <= 1'b1;
    @(posedge core_clk_i);
    commutation_i <= 1'b0;
  endtask : step
  // Selector 0 waits on the demag irq, 1 on the delay trigger
  task automatic wait_for(input int sel, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(negedge core_clk_i);
      if ((sel == 0 ? demag_irq_o : delay_trigger_o) === 1'b1) break;
    end
    if (i == lim) begin
      bad_count++;
      $display("Error at %0t: event %0d never came", $time, sel);
      stop_test();
    end
  endtask : wait_for
  task automatic t_regs();
    rchk(ADDR_CTRL, 8'hff, CTRL_RESET, "ctrl reset");
    rchk(ADDR_DEMAG, 8'hff, DEMAG_RESET, "demag reset");
    wr(4'hf, 8'hff);
    rchk(4'hf, 8'hff, 8'h00, "unmapped read");
    wr(ADDR_SEL, 8'h6d);
    repeat (2) @(negedge core_clk_i);
    chk({6'h0, input_select_o}, 8'h01, "input select");
    chk({6'h0, reference_level_select_o}, 8'h03, "reference select");
    chk({5'h0, output_group_config_o}, 8'h06, "output group");
    $display("register test done");
  endtask : t_regs
  task automatic t_hw();
    mph = 2'h2;
    tbase = 8'h5a;
    wr(ADDR_DEMAG, 8'hf0);
    step(8'h02, 8'h06, 8'h03);
    wait_for(0, 1000);
    rchk(ADDR_STATUS, 8'h0d, 8'h09, "demag flag and step");
    chk({7'h0, pwm_regroup_o}, 8'h01, "regroup after demag");
    rchk(ADDR_DEMAG, 8'hff, 8'h5a, "captured timer");
    chk(8'(trig_n), 8'h00, "early zero cross");
    wait_for(1, 1000);
    chk({7'h0, zero_cross_irq_o}, 8'h01, "zero irq");
    rchk(ADDR_STATUS, 8'h0e, 8'h02, "zero flag");
    wr(ADDR_STATUS, 8'h03);
    rchk(ADDR_STATUS, 8'h01, 8'h00, "flag clear");
    $display("hardware demag test done");
  endtask : t_hw
  task automatic t_sw();
    ddly = 16'h8000;
    tbase = 8'h00;
    trun = 1'b1;
    wr(ADDR_DEMAG, 8'h30);
    step(8'h02, 8'h04, 8'h01);
    for (int i = 0; i < 80 && motor_timer_i !== 8'h2e; i++)
      @(negedge core_clk_i);
    chk(motor_timer_i, 8'h2e, "timer walk");
    chk({7'h0, demag_irq_o}, 8'h00, "early simulated demag");
    wait_for(0, 8);
    rchk(ADDR_DEMAG, 8'hff, 8'h30, "compare kept");
    wr(ADDR_STATUS, 8'h03);
    trun = 1'b0;
    $display("software demag test done");
  endtask : t_sw
  task automatic t_mask();
    mph = 2'h0;
    mpol = 1'b1;
    ddly = 16'd400;
    tbase = 8'h11;
    step(8'h00, 8'h6a, 8'h10);
    repeat (2000) @(negedge core_clk_i);
    chk({6'h0, demag_irq_o, zero_cross_irq_o}, 8'h00, "masked irqs");
    chk(8'(trig_n), 8'h01, "zero cross off group");
    rchk(ADDR_STATUS, 8'h01, 8'h01, "inverted demag flag");
    rchk(ADDR_DEMAG, 8'hff, 8'h11, "captured timer");
    wr(ADDR_STATUS, 8'h03);
    $display("mask test done");
  endtask : t_mask
  task automatic t_sensor();
    mph = 2'h1;
    step(8'h01, 8'h31, 8'h03);
    wait_for(1, 1500);
    chk({7'h0, zero_cross_irq_o}, 8'h01, "sensor zero irq");
    rchk(ADDR_STATUS, 8'h01, 8'h00, "no demag in sensor mode");
    $display("sensor test done");
  endtask : t_sensor
  initial begin
    repeat (16) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    t_regs();
    t_hw();
    t_sw();
    t_mask();
    t_sensor();
    stop_test();
  end
endmodule : tb_bzcd_detector
